// ### hdl/mio_irq_option.sv
// interrupt option register, vector map, power modes and ahb-lite slave
// Function
// - level_edge_select 0: port A vector latches falling edges.
// - level_edge_select 1: port A vector follows low level, nothing stored.
// - edge_polarity_select bit 5: port B/C falling when 0, rising when 1.
// - global_irq_enable bit 4 gates all maskable requests, and the nmi only as a wake source.
// - nmi serviced with enable cleared, but then cannot end stop or wait.
// - port A requests use vector FF6h-FF7h and can end stop.
// - port B and C requests share vector FF4h-FF5h and can end stop.
// - any reset enters run state, never a power saving state.
// - in run, core and peripherals clocked from the main oscillator.
// - auxiliary oscillator may replace main one in run and wait.
// - each power saving state entered only by its own instruction.
// - auxiliary oscillator selected by setting its control bit.
// - option register written whole, reads return no stored value.
// - edge mode keeps one pending request until its service starts.
`timescale 1ns/1ps
`default_nettype none
module mio_irq_option
  import mio_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // external pins, asynchronous
  input wire logic nmi_n,
  input wire logic port_a_line,
  input wire logic port_bc_line,
  // peripheral flags and their enables, same clock
  input wire logic timer_zero_flag,
  input wire logic timer_irq_en,
  input wire logic conv_done_flag,
  input wire logic conv_irq_en,
  // processor core
  input wire logic exec_wait,
  input wire logic exec_stop,
  input wire logic vec_ack,
  output logic irq_req,
  output logic irq_is_nmi,
  output logic [11:0] irq_vector,
  // clock control
  output logic main_osc_run,
  output logic aux_osc_run,
  output logic clk_sel_aux,
  output logic cpu_clk_run,
  output logic periph_clk_run,
  output logic [2:0] pwr_state,
  // interrupt
  output logic irq
);
  // option register fields, bits 7 and 3:0 are not stored
  logic level_edge_select_ff;
  logic edge_polarity_select_ff;
  logic global_irq_enable_ff;
  logic aux_low_freq_osc_ff;
  logic [3:0] evt_status_ff;
  logic [3:0] evt_mask_ff;
  logic [3:0] evt_set;
  logic nmi_latch_ff;
  logic a_latch_ff;
  logic bc_latch_ff;
  logic irq_req_ff;
  logic irq_is_nmi_ff;
  logic [11:0] irq_vector_ff;
  logic [11:0] nxt_vector;
  logic nxt_req;
  logic nxt_is_nmi;
  mio_pwr_t pwr_ff;
  mio_pwr_t nxt_pwr;
  // bus data-phase capture
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic addr_ok;
  // synchronised pins
  logic [MIO_LINES-1:0] pin_raw;
  logic [MIO_LINES-1:0] pin_lvl;
  logic [MIO_LINES-1:0] pin_rise;
  logic [MIO_LINES-1:0] pin_fall;
  // request terms
  logic a_req;
  logic bc_edge;
  logic timer_req;
  logic conv_req;
  logic any_maskable;
  logic nmi_ack;
  logic a_ack;
  logic bc_ack;
  logic stop_wake;
  logic wait_wake;
  logic opt_wr;

  assign pin_raw[MIO_LINE_NMI] = nmi_n;
  assign pin_raw[MIO_LINE_A] = port_a_line;
  assign pin_raw[MIO_LINE_BC] = port_bc_line;

  // one synchroniser per pin line
  genvar gi;
  generate
    for (gi = 0; gi < MIO_LINES; gi++)
    begin : g_sync
      mio_pin_sync u_sync
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(pin_raw[gi]),
        .level(pin_lvl[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  // ahb address phase decode; the slave never stalls
  assign addr_ok = hsel & hready & (htrans == MIO_HTRANS_NONSEQ | htrans == MIO_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = MIO_HRESP_OKAY;
  assign hrdata = hrdata_ff;

  // capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_ok & hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // read mux, sampled at the address phase so data stands in the data phase
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      MIO_OFS_OPTION: nxt_rdata = 32'h0000_0000;
      MIO_OFS_CLOCK: nxt_rdata[MIO_BIT_AUX_OSC] = aux_low_freq_osc_ff;
      MIO_OFS_STATE: nxt_rdata = {21'h000000, irq_is_nmi_ff, irq_req_ff, bc_latch_ff,
                                  a_latch_ff, nmi_latch_ff, pwr_ff, global_irq_enable_ff,
                                  edge_polarity_select_ff, level_edge_select_ff};
      MIO_OFS_IRQ_STATUS: nxt_rdata[MIO_EVT_W-1:0] = evt_status_ff;
      MIO_OFS_IRQ_MASK: nxt_rdata[MIO_EVT_W-1:0] = evt_mask_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data register, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (addr_ok & ~hwrite)
      hrdata_ff <= nxt_rdata;
  end

  assign opt_wr = wr_pend_ff & (wr_addr_ff == MIO_OFS_OPTION);

  // option register: whole-byte write only, unused bits dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level_edge_select_ff <= MIO_OPTION_RST[MIO_BIT_LEVEL_EDGE];
      edge_polarity_select_ff <= MIO_OPTION_RST[MIO_BIT_EDGE_POL];
      global_irq_enable_ff <= MIO_OPTION_RST[MIO_BIT_GLOBAL_EN];
    end
    else if (opt_wr)
    begin
      level_edge_select_ff <= hwdata[MIO_BIT_LEVEL_EDGE];
      edge_polarity_select_ff <= hwdata[MIO_BIT_EDGE_POL];
      global_irq_enable_ff <= hwdata[MIO_BIT_GLOBAL_EN];
    end
  end

  // clock source control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aux_low_freq_osc_ff <= MIO_AUX_OSC_RST;
    else if (wr_pend_ff & (wr_addr_ff == MIO_OFS_CLOCK))
      aux_low_freq_osc_ff <= hwdata[MIO_BIT_AUX_OSC];
  end

  // service start of the vector now presented clears its latch
  assign nmi_ack = vec_ack & irq_req_ff & irq_is_nmi_ff;
  assign a_ack = vec_ack & irq_req_ff & ~irq_is_nmi_ff & (irq_vector_ff == MIO_VEC_PORT_A);
  assign bc_ack = vec_ack & irq_req_ff & ~irq_is_nmi_ff & (irq_vector_ff == MIO_VEC_PORT_BC);

  assign bc_edge = edge_polarity_select_ff ? pin_rise[MIO_LINE_BC] : pin_fall[MIO_LINE_BC];

  // request latches; a new edge in the ack cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nmi_latch_ff <= 1'b0;
      a_latch_ff <= 1'b0;
      bc_latch_ff <= 1'b0;
    end
    else
    begin
      nmi_latch_ff <= pin_fall[MIO_LINE_NMI] | (nmi_latch_ff & ~nmi_ack);
      a_latch_ff <= ~level_edge_select_ff &
                    (pin_fall[MIO_LINE_A] | (a_latch_ff & ~a_ack));
      bc_latch_ff <= bc_edge | (bc_latch_ff & ~bc_ack);
    end
  end

  assign a_req = level_edge_select_ff ? ~pin_lvl[MIO_LINE_A] : a_latch_ff;
  assign timer_req = timer_zero_flag & timer_irq_en;
  assign conv_req = conv_done_flag & conv_irq_en;
  assign any_maskable = a_req | bc_latch_ff | timer_req | conv_req;

  // fixed priority vector selection
  always_comb
  begin
    nxt_req = 1'b0;
    nxt_is_nmi = 1'b0;
    nxt_vector = MIO_VEC_RST;
    if (nmi_latch_ff)
    begin
      nxt_req = 1'b1;
      nxt_is_nmi = 1'b1;
      nxt_vector = MIO_VEC_NMI;
    end
    else if (global_irq_enable_ff)
    begin
      if (a_req)
      begin
        nxt_req = 1'b1;
        nxt_vector = MIO_VEC_PORT_A;
      end
      else if (bc_latch_ff)
      begin
        nxt_req = 1'b1;
        nxt_vector = MIO_VEC_PORT_BC;
      end
      else if (timer_req)
      begin
        nxt_req = 1'b1;
        nxt_vector = MIO_VEC_TIMER;
      end
      else if (conv_req)
      begin
        nxt_req = 1'b1;
        nxt_vector = MIO_VEC_CONV;
      end
    end
  end

  // registered request presented to the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_ff <= 1'b0;
      irq_is_nmi_ff <= 1'b0;
      irq_vector_ff <= MIO_VEC_RST;
    end
    else
    begin
      irq_req_ff <= nxt_req;
      irq_is_nmi_ff <= nxt_is_nmi;
      irq_vector_ff <= nxt_vector;
    end
  end

  assign irq_req = irq_req_ff;
  assign irq_is_nmi = irq_is_nmi_ff;
  assign irq_vector = irq_vector_ff;

  // nmi wakes only with enable set
  assign stop_wake = (nmi_latch_ff | a_req | bc_latch_ff | timer_req) & global_irq_enable_ff;
  assign wait_wake = (nmi_latch_ff | any_maskable) & global_irq_enable_ff;

  // power state sequencing
  always_comb
  begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      MIO_RUN:
        // entry by instruction only; refused while a request waits
        if (exec_stop & ~nxt_req)
          nxt_pwr = MIO_STOP;
        else if (exec_wait & ~nxt_req)
          nxt_pwr = MIO_WAIT;
      MIO_WAIT:
        if (wait_wake)
          nxt_pwr = MIO_RUN;
      MIO_STOP:
        if (stop_wake)
          nxt_pwr = MIO_RUN;
      default: nxt_pwr = MIO_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pwr_ff <= MIO_RUN;
    else
      pwr_ff <= nxt_pwr;
  end

  // clock gating from power state; stop halts both oscillators
  // main oscillator in run
  // aux replaces main in run and wait
  assign clk_sel_aux = aux_low_freq_osc_ff;
  assign aux_osc_run = aux_low_freq_osc_ff & (pwr_ff != MIO_STOP);
  assign main_osc_run = ~aux_low_freq_osc_ff & (pwr_ff != MIO_STOP);
  assign cpu_clk_run = (pwr_ff == MIO_RUN);
  assign periph_clk_run = (pwr_ff != MIO_STOP);
  assign pwr_state = pwr_ff;

  // sticky events, set wins over a write-one clear
  assign evt_set[MIO_EVT_NMI] = pin_fall[MIO_LINE_NMI];
  // port A falling edges are recorded in both sensing modes
  assign evt_set[MIO_EVT_PORT_A] = pin_fall[MIO_LINE_A];
  assign evt_set[MIO_EVT_PORT_BC] = bc_edge;
  assign evt_set[MIO_EVT_WAKE] = (pwr_ff != MIO_RUN) & (nxt_pwr == MIO_RUN);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      evt_status_ff <= MIO_EVT_RST;
    else if (wr_pend_ff & (wr_addr_ff == MIO_OFS_IRQ_STATUS))
      evt_status_ff <= evt_set | (evt_status_ff & ~hwdata[MIO_EVT_W-1:0]);
    else
      evt_status_ff <= evt_set | evt_status_ff;
  end

  // event mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      evt_mask_ff <= MIO_EVT_RST;
    else if (wr_pend_ff & (wr_addr_ff == MIO_OFS_IRQ_MASK))
      evt_mask_ff <= hwdata[MIO_EVT_W-1:0];
  end

  // level interrupt, high while any unmasked event is set
  assign irq = |(evt_status_ff & evt_mask_ff);
endmodule
`default_nettype wire

// ### hdl/mio_pin_sync.sv
// two-stage synchroniser for one pin line with edge pulses
`timescale 1ns/1ps
`default_nettype none
module mio_pin_sync
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw pin
  input wire logic pin,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // first stage feeds only the second; pins idle high (pull-up)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges seen on the synchronised level only
  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ### hdl/mio_pkg.sv
// shared constants for the interrupt option and vector map block
package mio_pkg;
  // register byte offsets
  localparam logic [7:0] MIO_OFS_OPTION = 8'h00;
  localparam logic [7:0] MIO_OFS_CLOCK = 8'h04;
  localparam logic [7:0] MIO_OFS_STATE = 8'h08;
  localparam logic [7:0] MIO_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] MIO_OFS_IRQ_MASK = 8'h10;
  // interrupt option fields
  localparam int MIO_BIT_LEVEL_EDGE = 6;
  localparam int MIO_BIT_EDGE_POL = 5;
  localparam int MIO_BIT_GLOBAL_EN = 4;
  localparam logic [7:0] MIO_OPTION_RST = 8'h00;
  // clock control field
  localparam int MIO_BIT_AUX_OSC = 0;
  localparam logic MIO_AUX_OSC_RST = 1'b0;
  // event status bits
  localparam int MIO_EVT_NMI = 0;
  localparam int MIO_EVT_PORT_A = 1;
  localparam int MIO_EVT_PORT_BC = 2;
  localparam int MIO_EVT_WAKE = 3;
  localparam int MIO_EVT_W = 4;
  localparam logic [3:0] MIO_EVT_RST = 4'h0;
  // vector fetch addresses, first byte of each pair
  localparam logic [11:0] MIO_VEC_NMI = 12'hFFC;
  localparam logic [11:0] MIO_VEC_PORT_A = 12'hFF6;
  localparam logic [11:0] MIO_VEC_PORT_BC = 12'hFF4;
  localparam logic [11:0] MIO_VEC_TIMER = 12'hFF2;
  localparam logic [11:0] MIO_VEC_CONV = 12'hFF0;
  localparam logic [11:0] MIO_VEC_RST = 12'h000;
  // synchronised pin lines
  localparam int MIO_LINE_NMI = 0;
  localparam int MIO_LINE_A = 1;
  localparam int MIO_LINE_BC = 2;
  localparam int MIO_LINES = 3;
  // ahb encodings
  localparam logic [1:0] MIO_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] MIO_HTRANS_SEQ = 2'b11;
  localparam logic [1:0] MIO_HRESP_OKAY = 2'b00;
  // power states
  typedef enum logic [2:0] {
    MIO_RUN = 3'b001,
    MIO_WAIT = 3'b010,
    MIO_STOP = 3'b100
  } mio_pwr_t;
endpackage

// ### sim/mio_core_model.sv
// processor core model fetching vectors after a short or long delay
`timescale 1ns/1ps
`default_nettype none
module mio_core_model
  import mio_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request from the block
  input wire logic irq_req,
  input wire logic [11:0] irq_vector,
  // bench controls
  input wire logic ack_en,
  input wire logic ack_slow,
  // service start and fetched vector
  output logic vec_ack,
  output logic [11:0] last_vec
);
  logic [2:0] wait_ff;
  // one pulse per request; the fast path still waits two cycles so that
  // a request that has just been taken is gone before the next ack
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_ack <= 1'b0;
      wait_ff <= 3'h0;
      last_vec <= 12'h000;
    end
    else if (irq_req && ack_en && !vec_ack && wait_ff >= (ack_slow ? 3'h4 : 3'h2))
    begin
      vec_ack <= 1'b1;
      wait_ff <= 3'h0;
      last_vec <= irq_vector;
    end
    else
    begin
      vec_ack <= 1'b0;
      wait_ff <= (irq_req && ack_en) ? wait_ff + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

// ### sim/mio_irq_option_asserts.sv
// port-level checks for the interrupt option and vector map block
`timescale 1ns/1ps
`default_nettype none
module mio_irq_option_asserts
  import mio_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // core side
  input wire logic exec_wait,
  input wire logic exec_stop,
  input wire logic vec_ack,
  input wire logic irq_req,
  input wire logic irq_is_nmi,
  input wire logic [11:0] irq_vector,
  // clock control
  input wire logic aux_osc_run,
  input wire logic clk_sel_aux,
  input wire logic cpu_clk_run,
  input wire logic periph_clk_run,
  input wire logic [2:0] pwr_state
);
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_reset_run;
    $rose(hresetn) |-> pwr_state == MIO_RUN;
  endproperty
  a_reset_run: assert property (p_reset_run) else $error("not run after reset");
  property p_opt_wo;
    hsel && hready && htrans == MIO_HTRANS_NONSEQ && !hwrite
      && haddr == {24'h0, MIO_OFS_OPTION} |=> hrdata == 32'h0;
  endproperty
  a_opt_wo: assert property (p_opt_wo) else $error("option read not zero");
  property p_nmi_flag;
    irq_req |-> irq_is_nmi == (irq_vector == MIO_VEC_NMI);
  endproperty
  a_nmi_flag: assert property (p_nmi_flag) else $error("nmi flag and vector disagree");
  property p_run_clk;
    pwr_state == MIO_RUN |-> cpu_clk_run && periph_clk_run;
  endproperty
  a_run_clk: assert property (p_run_clk) else $error("clocks off in run");
  property p_aux_osc;
    clk_sel_aux && pwr_state != MIO_STOP |-> aux_osc_run;
  endproperty
  a_aux_osc: assert property (p_aux_osc) else $error("aux selected but idle");
  property p_run_hold;
    pwr_state == MIO_RUN && !exec_wait && !exec_stop |=> pwr_state == MIO_RUN;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("left run unasked");
  property p_stop_exit;
    pwr_state == MIO_STOP ##1 pwr_state != MIO_STOP |-> pwr_state == MIO_RUN;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop left to non-run");
  property p_conv_nowake;
    pwr_state == MIO_STOP && irq_req && irq_vector == MIO_VEC_CONV |=> pwr_state == MIO_STOP;
  endproperty
  a_conv_nowake: assert property (p_conv_nowake) else $error("converter woke stop");
  property p_bc_ack;
    vec_ack && irq_req && irq_vector == MIO_VEC_PORT_BC |-> ##2 irq_vector != MIO_VEC_PORT_BC;
  endproperty
  a_bc_ack: assert property (p_bc_ack) else $error("shared latch kept after ack");
endmodule

bind mio_irq_option mio_irq_option_asserts u_mio_irq_option_asserts (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .exec_wait, .exec_stop, .vec_ack,
  .irq_req, .irq_is_nmi, .irq_vector, .aux_osc_run, .clk_sel_aux, .cpu_clk_run,
  .periph_clk_run, .pwr_state);
`default_nettype wire

// ### sim/tb_mio_irq_option.sv
// self-checking bench for the interrupt option and vector map block
`timescale 1ns/1ps
`default_nettype none
module tb_mio_irq_option
  import mio_pkg::*;
;
  // bus and outputs
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic hreadyout, vec_ack, irq_req, irq_is_nmi, irq, aux_run, sel_aux, main_run;
  // pins, flags and core controls
  logic nmi_n = 1'b1, port_a_line = 1'b1, port_bc_line = 1'b1;
  logic tmr = 1'b0, tmr_en = 1'b0, conv = 1'b0, conv_en = 1'b0;
  logic exec_wait = 1'b0, exec_stop = 1'b0, ack_en = 1'b1, ack_slow = 1'b0;
  logic [11:0] irq_vector, last_vec;
  logic [2:0] pwr_state;
  int failures = 0;
  int checks_done = 0;

  // 200 MHz clock
  always #2.5 hclk = ~hclk;
  mio_irq_option u_mio_irq_option (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .nmi_n,
    .port_a_line, .port_bc_line, .timer_zero_flag(tmr), .timer_irq_en(tmr_en),
    .conv_done_flag(conv), .conv_irq_en(conv_en), .exec_wait, .exec_stop, .vec_ack,
    .irq_req, .irq_is_nmi, .irq_vector, .main_osc_run(main_run), .aux_osc_run(aux_run),
    .clk_sel_aux(sel_aux), .cpu_clk_run(), .periph_clk_run(), .pwr_state, .irq);
  mio_core_model u_mio_core_model (.hclk, .hresetn, .irq_req, .irq_vector, .ack_en,
    .ack_slow, .vec_ack, .last_vec);

  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    failures++;
    stop_test();
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // waits for hready; a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        hang();
      @(posedge hclk);
    end
  endtask
  // one single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= MIO_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // upper nibble only, low bits always zero
  task automatic opt(input logic [3:0] v);
    ahb(1'b1, MIO_OFS_OPTION, {24'h0, v, 4'h0});
  endtask
  // short low pulse on the chosen pins: bit0 nmi, bit1 port A, bit2 port B/C
  task automatic pulse(input logic [2:0] m);
    @(posedge hclk);
    {port_bc_line, port_a_line, nmi_n} <= ~m;
    look(3);
    @(posedge hclk);
    {port_bc_line, port_a_line, nmi_n} <= 3'b111;
  endtask
  task automatic wait_vec(input logic [11:0] v);
    int n;
    n = 0;
    #1;
    while (irq_req !== 1'b1)
    begin
      n++;
      if (n > 30)
        hang();
      look(1);
    end
    chk(irq_vector, v);
  endtask
  // pulse one sleep instruction, stop when s is set
  task automatic sleep(input logic s);
    @(posedge hclk);
    exec_stop <= s;
    exec_wait <= !s;
    @(posedge hclk);
    exec_stop <= 1'b0;
    exec_wait <= 1'b0;
    look(2);
  endtask

  // reset state, write-only option and an unmapped read
  task automatic t_reset;
    look(1);
    chk(12'(pwr_state), 12'(MIO_RUN));
    chk(12'(main_run), 12'h001);
    chk(12'(hresp), 12'(MIO_HRESP_OKAY));
    opt(4'h7);
    ahb(1'b0, MIO_OFS_STATE, 32'h0);
    chk(rd[11:0], 12'h00F);
    ahb(1'b0, MIO_OFS_OPTION, 32'h0);
    chk(rd[11:0], 12'h000);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd[11:0], 12'h000);
    opt(4'h0);
  endtask
  // nmi with maskables off, then a port A edge stored until enabled
  task automatic t_ext;
    pulse(3'b001);
    wait_vec(MIO_VEC_NMI);
    look(8);
    chk(last_vec, MIO_VEC_NMI);
    pulse(3'b010);
    look(8);
    chk(12'(irq_req), 12'h000);
    opt(4'h1);
    wait_vec(MIO_VEC_PORT_A);
    look(8);
    chk(12'(irq_req), 12'h000);
  endtask
  // level mode on port A keeps nothing once the line is high
  task automatic t_level;
    opt(4'h5);
    @(posedge hclk);
    port_a_line <= 1'b0;
    wait_vec(MIO_VEC_PORT_A);
    @(posedge hclk);
    port_a_line <= 1'b1;
    look(8);
    chk(12'(irq_req), 12'h000);
    opt(4'h1);
  endtask
  // shared vector: stored edge, then rising polarity with a slow core
  task automatic t_bc;
    @(posedge hclk);
    ack_en <= 1'b0;
    pulse(3'b100);
    wait_vec(MIO_VEC_PORT_BC);
    look(8);
    chk(12'(irq_req), 12'h001);
    @(posedge hclk);
    ack_en <= 1'b1;
    look(8);
    chk(12'(irq_req), 12'h000);
    opt(4'h3);
    @(posedge hclk);
    port_bc_line <= 1'b0;
    look(8);
    chk(12'(irq_req), 12'h000);
    @(posedge hclk);
    port_bc_line <= 1'b1;
    ack_slow <= 1'b1;
    wait_vec(MIO_VEC_PORT_BC);
    look(12);
    ack_slow <= 1'b0;
    opt(4'h1);
  endtask
  // timer beats converter; clearing the enable hides the converter
  task automatic t_prio;
    @(posedge hclk);
    ack_en <= 1'b0;
    tmr <= 1'b1;
    tmr_en <= 1'b1;
    conv <= 1'b1;
    conv_en <= 1'b1;
    wait_vec(MIO_VEC_TIMER);
    @(posedge hclk);
    tmr <= 1'b0;
    look(3);
    chk(irq_vector, MIO_VEC_CONV);
    opt(4'h0);
    look(3);
    chk(12'(irq_req), 12'h000);
    @(posedge hclk);
    conv <= 1'b0;
    ack_en <= 1'b1;
  endtask
  // sleep entry, port A, port B/C and timer wake sources, aux oscillator in wait
  task automatic t_power;
    opt(4'h1);
    sleep(1'b1);
    chk(12'(pwr_state), 12'(MIO_STOP));
    @(posedge hclk);
    conv <= 1'b1;
    look(8);
    chk(12'(pwr_state), 12'(MIO_STOP));
    @(posedge hclk);
    conv <= 1'b0;
    opt(4'h0);
    pulse(3'b001);
    look(8);
    chk(12'(pwr_state), 12'(MIO_STOP));
    opt(4'h1);
    pulse(3'b010);
    look(8);
    chk(12'(pwr_state), 12'(MIO_RUN));
    sleep(1'b1);
    pulse(3'b100);
    look(8);
    chk(12'(pwr_state), 12'(MIO_RUN));
    sleep(1'b1);
    @(posedge hclk);
    tmr <= 1'b1;
    look(8);
    chk(12'(pwr_state), 12'(MIO_RUN));
    @(posedge hclk);
    tmr <= 1'b0;
    ahb(1'b1, MIO_OFS_CLOCK, 32'h1);
    ahb(1'b0, MIO_OFS_CLOCK, 32'h0);
    chk(rd[11:0], 12'h001);
    sleep(1'b0);
    chk({8'h0, pwr_state == MIO_WAIT, sel_aux, aux_run, main_run}, 12'h00E);
    pulse(3'b010);
    look(8);
    chk(12'(pwr_state), 12'(MIO_RUN));
    ahb(1'b1, MIO_OFS_CLOCK, 32'h0);
  endtask
  // sticky status, mask and write-one clear
  task automatic t_irq;
    ahb(1'b1, MIO_OFS_IRQ_STATUS, 32'hF);
    ahb(1'b1, MIO_OFS_IRQ_MASK, 32'h2);
    pulse(3'b010);
    look(8);
    chk(12'(irq), 12'h001);
    ahb(1'b0, MIO_OFS_IRQ_STATUS, 32'h0);
    chk(rd[11:0], 12'h002);
    ahb(1'b1, MIO_OFS_IRQ_MASK, 32'h0);
    look(1);
    chk(12'(irq), 12'h000);
    ahb(1'b1, MIO_OFS_IRQ_STATUS, 32'h2);
    ahb(1'b0, MIO_OFS_IRQ_STATUS, 32'h0);
    chk(rd[11:0], 12'h000);
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ext();
    t_level();
    t_bc();
    t_prio();
    t_power();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
